// ---- hw/pio_consts.svh ----
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

// Gearbox word lengths, in bits
`define PIO_GEAR_RATIO_X4 4'h8
`define PIO_GEAR_RATIO_7 4'h7
`define PIO_GEAR_RATIO_X2 4'h4

// Field positions inside the core-side gearbox word
`define PIO_GEAR_HI_LSB 4
`define PIO_GEAR_HI_MSB 7
`define PIO_GEAR_LO_LSB 0
`define PIO_GEAR_LO_MSB 3

// Reset values
`define PIO_RST_BIT 1'h0
`define PIO_RST_WORD 8'h00
`define PIO_RST_COUNT 4'h0

`endif

// ---- hw/pio_pkg.sv ----
`default_nettype none
package pio_pkg;

    typedef enum logic [0:0] {
        PIO_IN_SDR,
        PIO_IN_DDR_MEM
    } pio_in_mode_e;

    typedef enum logic [1:0] {
        PIO_OUT_SDR_FF,
        PIO_OUT_SDR_LATCH,
        PIO_OUT_DDR_GEN,
        PIO_OUT_DDR_MEM
    } pio_out_mode_e;

    typedef enum logic [1:0] {
        PIO_GEAR_1TO7,
        PIO_GEAR_X4,
        PIO_GEAR_X2
    } pio_gear_mode_e;

    typedef enum logic [1:0] {
        PIO_GS_IDLE,
        PIO_GS_RUN,
        PIO_GS_SLIP
    } pio_gear_state_e;

endpackage : pio_pkg
`default_nettype wire

// ---- hw/pio_ddr_regs.sv ----
// Added by the designer: the placing of the registers and the strobe ports.
`timescale 1ns/10ps
`default_nettype none
`include "pio_consts.svh"

// Summary of operation
// RULE1 - Right-edge DDR memory input captures on read strobe rise and fall.
// RULE2 - Both captured input streams are resynchronised to the system clock.
// RULE3 - sync_clock_polarity picks the system clock phase doing the transfer.
// RULE4 - Read strobe and sync polarity arrive from the strobe control block.
// RULE5 - Right-edge input offers plain input plus DDR memory capture.
// RULE6 - Core output data is registered before reaching the pin.
// RULE7 - SDR output uses one element, configured as flip-flop or latch.
// RULE8 - Generic DDR registers even/odd on rise; odd to second phase on fall.
// RULE9 - Generic DDR pin mux alternates stages using the output clock phase.
// RULE10 - Right edge keeps SDR and generic DDR, adds DDR memory output.
// RULE11 - DDR memory output mux is switched by the shifted write strobe.
// RULE12 - SDR tri-state data passes one register to the output enable; here it passes two, ts_sdr_reg then pin_oe_reg.
// RULE13 - DDR memory tri-state adds a write-strobe register for the enable.
// RULE14 - Gearbox runs as 1:7, one 1:8 or two independent 1:4 deserialisers; here the two 1:4 lanes share one bit counter, one slip and one valid.
// RULE15 - Gearbox pipeline: edge sampling, word alignment, core transfer.
// RULE16 - Core pulses word_align_req to slip the gearbox word boundary.
// RULE17 - Reset clears all capture, output, tri-state and gearbox registers.
module pio_ddr_regs #(
    parameter bit RIGHT_EDGE = 1'b1,
    parameter int GEAR_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire pio_pkg::pio_in_mode_e in_mode,
    input wire pio_pkg::pio_out_mode_e out_mode,
    input wire pio_pkg::pio_gear_mode_e gear_mode,
    input wire logic pin_in,
    input wire logic read_strobe_shifted,
    input wire logic sync_clock_polarity,
    input wire logic write_strobe_shifted,
    input wire logic out_data_even,
    input wire logic out_data_odd,
    input wire logic latch_open,
    input wire logic tristate_data_in,
    input wire logic tristate_ctrl_in,
    input wire logic ser_in_a,
    input wire logic ser_in_b,
    input wire logic word_align_req,
    output logic core_in_even,
    output logic core_in_odd,
    output logic pin_out,
    output logic pin_oe,
    output logic [GEAR_W-1:0] gear_word,
    output logic gear_valid
);
    import pio_pkg::*;

    function automatic logic rose(input logic prev, input logic cur);
        rose = cur & ~prev;
    endfunction : rose

    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction : fell

    // Memory modes exist only on right-edge cells; elsewhere fall back
    wire logic mem_in_mode;
    wire logic mem_out_mode;
    assign mem_in_mode = RIGHT_EDGE && (in_mode == PIO_IN_DDR_MEM); // RULE5
    assign mem_out_mode = RIGHT_EDGE
        && (out_mode == PIO_OUT_DDR_MEM); // RULE10

    // Output clock and system clock phases, both derived from clk
    logic out_phase_reg;
    logic out_phase_next;
    logic sys_phase_reg;
    logic sys_phase_next;
    assign out_phase_next = ~out_phase_reg;
    assign sys_phase_next = ~sys_phase_reg;

    wire logic out_rise;
    wire logic out_fall;
    assign out_rise = out_phase_next;
    assign out_fall = ~out_phase_next;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            out_phase_reg <= `PIO_RST_BIT; // RULE17
            sys_phase_reg <= `PIO_RST_BIT;
        end
        else
        begin
            out_phase_reg <= out_phase_next;
            sys_phase_reg <= sys_phase_next;
        end
    end

    // Strobe history for edge detection
    logic rds_prev_reg;
    logic wrs_prev_reg;
    wire logic rds_rise;
    wire logic rds_fall;
    wire logic wrs_rise;
    assign rds_rise = rose(rds_prev_reg, read_strobe_shifted); // RULE4
    assign rds_fall = fell(rds_prev_reg, read_strobe_shifted); // RULE4
    assign wrs_rise = rose(wrs_prev_reg, write_strobe_shifted);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rds_prev_reg <= `PIO_RST_BIT;
            wrs_prev_reg <= `PIO_RST_BIT;
        end
        else
        begin
            rds_prev_reg <= read_strobe_shifted;
            wrs_prev_reg <= write_strobe_shifted;
        end
    end

    // Input capture: two streams on the read strobe edges
    logic cap_rise_reg;
    logic cap_fall_reg;
    logic cap_rise_next;
    logic cap_fall_next;
    assign cap_rise_next = rds_rise ? pin_in : cap_rise_reg; // RULE1
    assign cap_fall_next = rds_fall ? pin_in : cap_fall_reg; // RULE1

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cap_rise_reg <= `PIO_RST_BIT;
            cap_fall_reg <= `PIO_RST_BIT;
        end
        else
        begin
            cap_rise_reg <= cap_rise_next;
            cap_fall_reg <= cap_fall_next;
        end
    end

    // Resync happens only on the chosen system clock phase, which
    // keeps the transfer away from the strobe capture instant
    wire logic sync_take;
    assign sync_take = (sys_phase_reg == sync_clock_polarity); // RULE3

    logic core_even_reg;
    logic core_odd_reg;
    logic core_even_next;
    logic core_odd_next;
    assign core_even_next = !mem_in_mode ? pin_in
        : (sync_take ? cap_rise_reg : core_even_reg); // RULE2
    assign core_odd_next = !mem_in_mode ? core_odd_reg
        : (sync_take ? cap_fall_reg : core_odd_reg); // RULE2

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            core_even_reg <= `PIO_RST_BIT;
            core_odd_reg <= `PIO_RST_BIT;
        end
        else
        begin
            core_even_reg <= core_even_next; // RULE5
            core_odd_reg <= core_odd_next;
        end
    end

    assign core_in_even = core_even_reg;
    assign core_in_odd = core_odd_reg;

    // Output path
    logic first_stage_reg;
    logic odd_stage_reg;
    logic second_phase_reg;
    logic first_stage_next;
    logic odd_stage_next;
    logic second_phase_next;
    assign first_stage_next = out_rise ? out_data_even
        : first_stage_reg; // RULE8
    assign odd_stage_next = out_rise ? out_data_odd : odd_stage_reg; // RULE8
    assign second_phase_next = out_fall ? odd_stage_reg
        : second_phase_reg; // RULE8

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            first_stage_reg <= `PIO_RST_BIT;
            odd_stage_reg <= `PIO_RST_BIT;
            second_phase_reg <= `PIO_RST_BIT;
        end
        else
        begin
            first_stage_reg <= first_stage_next; // RULE6
            odd_stage_reg <= odd_stage_next;
            second_phase_reg <= second_phase_next;
        end
    end

    // Latch is emulated by a load-while-open flop: one cycle of delay
    // is the price of keeping the pin path fully synchronous
    logic pin_out_reg;
    logic pin_out_next;
    always_comb
    begin
        pin_out_next = pin_out_reg;
        case (out_mode)
            PIO_OUT_SDR_FF:
                pin_out_next = out_data_even; // RULE7
            PIO_OUT_SDR_LATCH:
                pin_out_next = latch_open ? out_data_even
                    : pin_out_reg; // RULE7
            PIO_OUT_DDR_GEN:
                pin_out_next = out_phase_reg ? first_stage_reg
                    : second_phase_reg; // RULE9
            PIO_OUT_DDR_MEM:
                if (mem_out_mode)
                begin
                    pin_out_next = write_strobe_shifted ? first_stage_reg
                        : second_phase_reg; // RULE11
                end
                else
                begin
                    pin_out_next = out_phase_reg ? first_stage_reg
                        : second_phase_reg; // RULE10
                end
            default:
                pin_out_next = pin_out_reg;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_out_reg <= `PIO_RST_BIT;
        end
        else
        begin
            pin_out_reg <= pin_out_next; // RULE6
        end
    end

    assign pin_out = pin_out_reg;

    // Tri-state path; control high means the pin floats
    logic ts_sdr_reg;
    logic ts_ctrl_reg;
    logic ts_strobe_reg;
    logic pin_oe_reg;
    logic ts_strobe_next;
    logic pin_oe_next;
    assign ts_strobe_next = wrs_rise ? ts_ctrl_reg : ts_strobe_reg; // RULE13
    assign pin_oe_next = mem_out_mode ? ~ts_strobe_reg
        : ~ts_sdr_reg; // RULE12

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ts_sdr_reg <= `PIO_RST_BIT;
            ts_ctrl_reg <= `PIO_RST_BIT;
            ts_strobe_reg <= `PIO_RST_BIT;
            pin_oe_reg <= `PIO_RST_BIT; // RULE17
        end
        else
        begin
            ts_sdr_reg <= tristate_data_in; // RULE12
            ts_ctrl_reg <= tristate_ctrl_in; // RULE13
            ts_strobe_reg <= ts_strobe_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    assign pin_oe = pin_oe_reg;

    // Gearbox stage 1: each clk stands for one edge of the edge clock
    logic [GEAR_W-1:0] shift_a_reg;
    logic [GEAR_W-1:0] shift_b_reg;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            shift_a_reg <= GEAR_W'(`PIO_RST_WORD); // RULE17
            shift_b_reg <= GEAR_W'(`PIO_RST_WORD);
        end
        else
        begin
            shift_a_reg <= {shift_a_reg[GEAR_W-2:0], ser_in_a}; // RULE15
            shift_b_reg <= {shift_b_reg[GEAR_W-2:0], ser_in_b}; // RULE15
        end
    end

    // Gearbox stage 2: word boundary counter with slip on request
    wire logic [3:0] gear_len;
    assign gear_len = (gear_mode == PIO_GEAR_1TO7) ? `PIO_GEAR_RATIO_7
        : (gear_mode == PIO_GEAR_X2) ? `PIO_GEAR_RATIO_X2
        : `PIO_GEAR_RATIO_X4; // RULE14

    pio_gear_state_e gstate_reg;
    pio_gear_state_e gstate_next;
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    logic word_done;
    always_comb
    begin
        gstate_next = gstate_reg;
        bit_cnt_next = bit_cnt_reg;
        word_done = 1'b0;
        case (gstate_reg)
            PIO_GS_IDLE:
                gstate_next = PIO_GS_RUN;
            PIO_GS_RUN:
            begin
                // Count on here; only the SLIP hold delays, so one bit
                if (word_align_req)
                begin
                    gstate_next = PIO_GS_SLIP; // RULE16
                end
                if (bit_cnt_reg == gear_len - 4'h1)
                begin
                    bit_cnt_next = `PIO_RST_COUNT;
                    word_done = 1'b1;
                end
                else
                begin
                    bit_cnt_next = bit_cnt_reg + 4'h1;
                end
            end
            PIO_GS_SLIP:
                // Holding the count for one bit moves the boundary by one
                gstate_next = PIO_GS_RUN; // RULE16
            default:
                gstate_next = PIO_GS_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            gstate_reg <= PIO_GS_IDLE;
            bit_cnt_reg <= `PIO_RST_COUNT;
        end
        else
        begin
            gstate_reg <= gstate_next;
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    logic [GEAR_W-1:0] aligned_reg;
    logic aligned_valid_reg;
    logic [GEAR_W-1:0] aligned_next;
    always_comb
    begin
        aligned_next = aligned_reg;
        case (gear_mode)
            PIO_GEAR_1TO7:
                aligned_next = {1'b0, shift_a_reg[GEAR_W-2:0]};
            PIO_GEAR_X4:
                aligned_next = shift_a_reg;
            PIO_GEAR_X2:
            begin
                aligned_next[`PIO_GEAR_HI_MSB:`PIO_GEAR_HI_LSB] =
                    shift_a_reg[`PIO_GEAR_LO_MSB:`PIO_GEAR_LO_LSB]; // RULE14
                aligned_next[`PIO_GEAR_LO_MSB:`PIO_GEAR_LO_LSB] =
                    shift_b_reg[`PIO_GEAR_LO_MSB:`PIO_GEAR_LO_LSB]; // RULE14
            end
            default:
                aligned_next = shift_a_reg;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            aligned_reg <= GEAR_W'(`PIO_RST_WORD);
            aligned_valid_reg <= `PIO_RST_BIT;
        end
        else
        begin
            if (word_done)
            begin
                aligned_reg <= aligned_next; // RULE15
            end
            aligned_valid_reg <= word_done;
        end
    end

    // Gearbox stage 3: hand over to the core
    logic [GEAR_W-1:0] gear_word_reg;
    logic gear_valid_reg;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            gear_word_reg <= GEAR_W'(`PIO_RST_WORD);
            gear_valid_reg <= `PIO_RST_BIT;
        end
        else
        begin
            if (aligned_valid_reg)
            begin
                gear_word_reg <= aligned_reg; // RULE15
            end
            gear_valid_reg <= aligned_valid_reg;
        end
    end

    assign gear_word = gear_word_reg;
    assign gear_valid = gear_valid_reg;

endmodule : pio_ddr_regs
`default_nettype wire

// ---- verification/pio_ddr_regs_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module pio_ddr_regs_asserts #(
    parameter int GEAR_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire pio_pkg::pio_in_mode_e in_mode,
    input wire pio_pkg::pio_out_mode_e out_mode,
    input wire pio_pkg::pio_gear_mode_e gear_mode,
    input wire logic pin_in,
    input wire logic read_strobe_shifted,
    input wire logic sync_clock_polarity,
    input wire logic write_strobe_shifted,
    input wire logic out_data_even,
    input wire logic out_data_odd,
    input wire logic latch_open,
    input wire logic tristate_data_in,
    input wire logic tristate_ctrl_in,
    input wire logic ser_in_a,
    input wire logic ser_in_b,
    input wire logic word_align_req,
    input wire logic core_in_even,
    input wire logic core_in_odd,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic [GEAR_W-1:0] gear_word,
    input wire logic gear_valid
);
    import pio_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_reset_clears:
        assert property ($fell(srst) |-> !pin_out && !pin_oe && !gear_valid
            && gear_word == '0 && !core_in_even && !core_in_odd)
        else $error("outputs not cleared by reset");
    a_sdr_in_follow:
        assert property (in_mode == PIO_IN_SDR
            |=> core_in_even == $past(pin_in))
        else $error("sdr input not passed on");
    a_sdr_ff_out:
        assert property (out_mode == PIO_OUT_SDR_FF
            |=> pin_out == $past(out_data_even))
        else $error("sdr flop output wrong");
    a_latch_path:
        assert property (out_mode == PIO_OUT_SDR_LATCH |=> pin_out ==
            ($past(latch_open) ? $past(out_data_even) : $past(pin_out)))
        else $error("latch output wrong");
    a_gen_alternate:
        assert property ((out_mode == PIO_OUT_DDR_GEN && $stable(out_data_odd)
            && $stable(out_data_even) && out_data_even != out_data_odd)[*5]
            |-> pin_out != $past(pin_out))
        else $error("generic ddr output does not alternate");
    a_mem_out_mux:
        assert property ((out_mode == PIO_OUT_DDR_MEM && $stable(out_data_odd)
            && $stable(out_data_even))[*5] |-> pin_out ==
            ($past(write_strobe_shifted) ? out_data_even : out_data_odd))
        else $error("memory output mux wrong");
    a_sdr_oe_path:
        assert property ((out_mode == PIO_OUT_SDR_FF)[*3]
            |-> pin_oe == !$past(tristate_data_in, 2))
        else $error("sdr output enable wrong");
    a_x4_spacing:
        assert property (gear_valid && gear_mode == PIO_GEAR_X4
            |=> !gear_valid [*7])
        else $error("x4 words too close");
    a_x2_spacing:
        assert property (gear_valid && gear_mode == PIO_GEAR_X2
            |=> !gear_valid [*3])
        else $error("x2 words too close");
    a_word_holds:
        assert property ($changed(gear_word) |-> gear_valid)
        else $error("gear word changed without valid");
    a_seven_top:
        assert property (gear_valid && gear_mode == PIO_GEAR_1TO7
            |-> !gear_word[7])
        else $error("seven bit word has top bit set");

    c_seven: cover property (gear_valid && gear_mode == PIO_GEAR_1TO7);
    c_align: cover property (word_align_req ##[1:20] gear_valid);
    c_mem_out: cover property (out_mode == PIO_OUT_DDR_MEM
        && $rose(write_strobe_shifted));
endmodule : pio_ddr_regs_asserts

bind pio_ddr_regs pio_ddr_regs_asserts #(.GEAR_W(GEAR_W))
    pio_ddr_regs_asserts_i (.*);
`default_nettype wire

// ---- verification/pio_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pio_mem_model (
    input wire logic clk,
    input wire logic strobe_on,
    input wire logic [1:0] mem_data,
    input wire logic sdr_val,
    input wire logic [7:0] pat_a,
    input wire logic [7:0] pat_b,
    input wire logic [3:0] pat_len,
    output logic pin_in,
    output logic read_strobe_shifted,
    output logic write_strobe_shifted,
    output logic ser_in_a,
    output logic ser_in_b
);
    logic [1:0] div_reg = 2'h0;
    logic [3:0] idx_reg = 4'h0;
    logic [3:0] idx_next;

    assign idx_next = (idx_reg + 4'h1 >= pat_len) ? 4'h0 : idx_reg + 4'h1;
    always_ff @(posedge clk)
    begin
        div_reg <= div_reg + 2'h1;
        idx_reg <= idx_next;
    end
    // Strobes stand low between bursts
    assign read_strobe_shifted = strobe_on & div_reg[1];
    // Write strobe a quarter earlier, so mux and capture see other phases
    assign write_strobe_shifted = strobe_on
        & (div_reg[1] ^ div_reg[0]);
    assign pin_in = strobe_on ? (div_reg[1] ? mem_data[0] : mem_data[1])
        : sdr_val;
    assign ser_in_a = pat_a[idx_reg[2:0]];
    assign ser_in_b = pat_b[idx_reg[2:0]];
endmodule : pio_mem_model
`default_nettype wire

// ---- verification/pio_ddr_register_logic_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module pio_ddr_register_logic_tb;
    import pio_pkg::*;
    logic clk = 1'b0;
    logic srst, sync_clock_polarity, out_data_even, out_data_odd;
    logic latch_open, tristate_data_in, tristate_ctrl_in, word_align_req;
    logic strobe_on, sdr_val, pin_in, read_strobe_shifted;
    logic write_strobe_shifted, ser_in_a, ser_in_b;
    logic core_in_even, core_in_odd, pin_out, pin_oe, gear_valid;
    logic [1:0] mem_data;
    logic [3:0] pat_len;
    logic [7:0] pat_a, pat_b, gear_word;
    pio_in_mode_e in_mode;
    pio_out_mode_e out_mode;
    pio_gear_mode_e gear_mode;
    int fails = 0;
    int checks_done = 0;
    int gap = 0;
    logic [7:0] wq[$];
    int gq[$];

    always #20 clk = ~clk;

    pio_ddr_regs pio_ddr_regs_i (.*);
    pio_mem_model pio_mem_model_i (.*);

    always @(posedge clk)
    begin
        #1;
        gap = gap + 1;
        if (gear_valid === 1'b1)
        begin
            wq.push_back(gear_word);
            gq.push_back(gap);
            gap = 0;
        end
    end

    task automatic chk_word(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_pin(input logic got, input logic exp);
        chk_word({7'h00, got}, {7'h00, exp});
    endtask : chk_pin

    task automatic conclude();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic do_reset();
        srst <= 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
    endtask : do_reset

    // Words must repeat with a fixed period while the pattern repeats
    task automatic gear_run(input int len, output logic [7:0] first);
        repeat (30) @(posedge clk);
        wq.delete();
        gq.delete();
        repeat (40) @(posedge clk);
        #2;
        first = wq[0];
        chk_pin(wq.size() > 2, 1'b1);
        foreach (wq[k])
        begin
            chk_word(wq[k], first);
            if (k > 0)
                chk_word(8'(gq[k]), 8'(len));
        end
    endtask : gear_run

    initial
    begin
        #400000;
        fails++;
        conclude();
    end

    initial
    begin
        logic [7:0] r, w0, w1;
        logic pe, plo, pff, ps, ep, t1, t2, p1, w;
        pio_gear_mode_e gm[4];
        logic [7:0] ml[4];
        int gl[4];
        gm = '{PIO_GEAR_X4, PIO_GEAR_1TO7, PIO_GEAR_X2, PIO_GEAR_X2};
        gl = '{8, 7, 4, 4};
        ml = '{8'hFF, 8'h7F, 8'h0F, 8'h0F};
        {srst, sync_clock_polarity, out_data_even, out_data_odd} = 4'h0;
        {latch_open, tristate_data_in, tristate_ctrl_in} = 3'h0;
        {word_align_req, strobe_on, sdr_val, mem_data} = 5'h00;
        {pat_a, pat_b, pat_len} = 20'h0_0008;
        in_mode = PIO_IN_SDR;
        out_mode = PIO_OUT_SDR_FF;
        gear_mode = PIO_GEAR_X4;
        void'($urandom(91));
        {pe, plo, pff, ps, ep, t1, t2} = 7'h20;
        do_reset();
        for (int i = 0; i < 60; i++)
        begin
            @(posedge clk);
            r = 8'($urandom);
            out_data_even <= r[0];
            latch_open <= r[1];
            tristate_data_in <= r[2];
            sdr_val <= r[3];
            out_mode <= (i < 30) ? PIO_OUT_SDR_FF : PIO_OUT_SDR_LATCH;
            #1;
            if (pff | plo)
                ep = pe;
            if (i > 1)
            begin
                chk_pin(pin_out, ep);
                chk_pin(core_in_even, ps);
                chk_pin(pin_oe, ~t2);
            end
            {pe, plo, pff, ps, t2, t1} = {r[0], r[1], i < 30, r[3], t1, r[2]};
        end
        $display("test sdr done");
        out_mode <= PIO_OUT_DDR_GEN;
        for (int i = 0; i < 4; i++)
        begin
            {out_data_odd, out_data_even} <= 2'(i);
            repeat (7) @(posedge clk);
            #1;
            p1 = pin_out;
            @(posedge clk);
            #1;
            chk_pin(p1 | pin_out, i[0] | i[1]);
            chk_pin(p1 & pin_out, i[0] & i[1]);
        end
        $display("test generic ddr done");
        out_mode <= PIO_OUT_DDR_MEM;
        strobe_on <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            r = 8'($urandom);
            {out_data_odd, out_data_even} <= r[1:0];
            tristate_ctrl_in <= r[2];
            tristate_data_in <= ~r[2];
            repeat (8) @(posedge clk);
            #1;
            chk_pin(pin_oe, ~r[2]);
            for (int k = 0; k < 4; k++)
            begin
                w = write_strobe_shifted;
                @(posedge clk);
                #1;
                chk_pin(pin_out, w ? r[0] : r[1]);
            end
        end
        $display("test memory output done");
        in_mode <= PIO_IN_DDR_MEM;
        for (int i = 0; i < 8; i++)
        begin
            r = 8'($urandom);
            mem_data <= r[1:0];
            sync_clock_polarity <= i[2];
            repeat (16) @(posedge clk);
            #1;
            chk_pin(core_in_even, r[0]);
            chk_pin(core_in_odd, r[1]);
        end
        $display("test memory input done");
        strobe_on <= 1'b0;
        in_mode <= PIO_IN_SDR;
        out_mode <= PIO_OUT_SDR_FF;
        for (int i = 0; i < 4; i++)
        begin
            r = 8'($urandom);
            gear_mode <= gm[i];
            pat_len <= 4'(gl[i]);
            pat_a <= (i < 2) ? r : {8{i[0]}};
            pat_b <= {8{~i[0]}};
            do_reset();
            gear_run(gl[i], w0);
            if (i < 2)
                chk_word(8'($countones(w0)),
                    8'($countones(r & ml[i])));
            else
                chk_word(w0, {{4{i[0]}}, {4{~i[0]}}});
            if (i < 2)
            begin
                word_align_req <= 1'b1;
                @(posedge clk);
                word_align_req <= 1'b0;
                gear_run(gl[i], w1);
                w0 = (i == 0) ? {w0[6:0], w0[7]} : {1'b0, w0[5:0], w0[6]};
                chk_word(w1, w0);
            end
        end
        $display("test gearbox done");
        conclude();
    end
endmodule : pio_ddr_register_logic_tb
`default_nettype wire
